// File: fwp_pkg.sv
package fwp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          FWP_BLK_W          = 6;
  localparam logic [5:0]  FWP_LAST_BLK_16M   = 6'h26;  // Block 38
  localparam logic [5:0]  FWP_LAST_BLK_8M    = 6'h16;  // Block 22
  localparam logic [5:0]  FWP_BOT_MAIN_FIRST = 6'h08;  // First main block, bottom boot
  localparam logic [5:0]  FWP_BOT_PAR_LOCK   = 6'h01;  // Two lowest parameter blocks
  localparam logic [5:0]  FWP_TOP_MAIN_16M   = 6'h1E;  // Last main block, top boot, 16M
  localparam logic [5:0]  FWP_TOP_MAIN_8M    = 6'h0E;  // Last main block, top boot, 8M
  localparam logic [5:0]  FWP_TOP_PAR_OFS    = 6'h01;  // Top two parameter blocks

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FWP_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0]  FWP_CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0]  FWP_CMD_ERASE_SET  = 8'h20;
  localparam logic [7:0]  FWP_CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0]  FWP_CMD_READ_STAT  = 8'h70;
  localparam logic [7:0]  FWP_CMD_CLR_STAT   = 8'h50;

  // ----------------------------------------------------------------
  // Status bits and timing
  // ----------------------------------------------------------------
  localparam int          FWP_SR_READY       = 7;
  localparam int          FWP_SR_ERASE_ERR   = 5;
  localparam int          FWP_SR_PROG_ERR    = 4;
  localparam int          FWP_SR_SUPPLY_ERR  = 3;  // supply_lockout_error_bit
  localparam int          FWP_SR_LOCK_ERR    = 1;
  localparam logic [7:0]  FWP_SR_RESET       = 8'h80;
  localparam int          FWP_CLK_MHZ        = 20;
  localparam int          FWP_OP_TIME_US     = 10;
  localparam int          FWP_OP_CYCLES      = FWP_OP_TIME_US * FWP_CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FWP_FE_READ_ARRAY,
    FWP_FE_READ_STATUS,
    FWP_FE_PROG_WAIT,
    FWP_FE_ERASE_WAIT
  } fwp_front_e;

  typedef enum logic [1:0] {
    FWP_PWR_STANDBY,
    FWP_PWR_ACTIVE,
    FWP_PWR_AUTO_SAVE,
    FWP_PWR_RESET
  } fwp_power_e;

  // Host bus pins
  typedef struct packed {
    logic        chip_sel_n;
    logic        write_n;
    logic        out_en_n;
    logic        hw_reset_n;
    logic        write_prot_n;
    logic        vpp_ok;
    logic        vcc_ok;
    logic [5:0]  block;
    logic [15:0] word_addr;
    logic [7:0]  data;
  } fwp_bus_s;

  // Array write request toward the cell engine
  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [5:0]  block;
    logic [15:0] word_addr;
    logic [15:0] data;
  } fwp_array_req_s;

endpackage

// File: fwp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RQ1] Program supply below lockout: every program or erase fails, supply error set.
// [RQ2] Write-protect low: program or erase of a lockable block refused, error reported.
// [RQ3] Top boot: blocks 37,38,0-30 (16M) or 21,22,0-14 (8M) lockable.
// [RQ4] Bottom boot: blocks 0,1,8-38 (16M) or 0,1,8-22 (8M) lockable.
// [RQ5] Unlocked blocks program and erase normally when program supply is adequate.
// [RQ6] Hardware reset low keeps device disabled, every block treated locked.
// [RQ7] Chip select low with reset high means active mode.
// [RQ8] After an array read, enter auto power save holding output data.
// [RQ9] Chip select high in read mode: standby, data pins floated.
// [RQ10] Chip select high during program or erase: operation runs to completion.
// [RQ11] Command write taken only with write strobe and chip select both low.
// [RQ12] Array changes only after a complete two-step command sequence.
// [RQ13] Latched command unchanged by supply, chip-select or sequencer activity.
// [RQ14] Read-array mode at power-up, deep power-down exit, core supply recovery.
// [RQ15] Host issues read-array after program or erase before expecting array data.
// [RQ16] Host should tie hardware reset to system reset; the test host drives it independently.
// [RQ17] Lock conditions checked on confirm; array untouched when a lock error flags.
module fwp_ctrl
  import fwp_pkg::*;
#(
  parameter bit          TOP_BOOT  = 1'b1,
  parameter bit          DENS_16M  = 1'b1,
  parameter int unsigned OP_CYCLES = FWP_OP_CYCLES
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           reset_n,
  // Host pins, asynchronous
  input  wire fwp_bus_s       bus_pins,
  // Array read data
  input  wire logic [15:0]    array_rdata,
  // Data pins
  output logic [15:0]         data_out,
  output logic                data_oe,
  // Array write request
  output fwp_array_req_s      array_req,
  // Mode indication
  output fwp_power_e          power_mode,
  output logic [7:0]          status
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  fwp_bus_s sync1_q, sync1_d, sync2_q, sync2_d;

  // Two stages for every pin
  always_comb begin
    sync1_d = bus_pins;
    sync2_d = sync1_q;
  end

  always_ff @(posedge clock) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
  end

  // ----------------------------------------------------------------
  // Lock decode
  // ----------------------------------------------------------------
  logic [5:0] last_blk;
  logic [5:0] top_main_last;
  logic       blk_lockable;
  logic       blk_locked;
  logic       write_strobe;
  logic       wr_prev_q, wr_prev_d;

  // Lockable set per boot arrangement and density
  always_comb begin
    last_blk      = DENS_16M ? FWP_LAST_BLK_16M : FWP_LAST_BLK_8M;
    top_main_last = DENS_16M ? FWP_TOP_MAIN_16M : FWP_TOP_MAIN_8M;
    if (TOP_BOOT) begin
      blk_lockable = (sync2_q.block <= top_main_last) ||                  // RQ3
                     (sync2_q.block >= last_blk - FWP_TOP_PAR_OFS &&
                      sync2_q.block <= last_blk);
    end else begin
      blk_lockable = (sync2_q.block <= FWP_BOT_PAR_LOCK) ||               // RQ4
                     (sync2_q.block >= FWP_BOT_MAIN_FIRST &&
                      sync2_q.block <= last_blk);
    end
    blk_locked = !sync2_q.hw_reset_n ||                                   // RQ6
                 (!sync2_q.write_prot_n && blk_lockable);                 // RQ2
  end

  // Write taken on rising edge of the combined strobe
  always_comb begin
    wr_prev_d    = !sync2_q.write_n && !sync2_q.chip_sel_n;               // RQ11
    write_strobe = wr_prev_q && !wr_prev_d && sync2_q.hw_reset_n;
  end

  // ----------------------------------------------------------------
  // Command front end and sequencer
  // ----------------------------------------------------------------
  fwp_front_e     front_q, front_d;
  logic [7:0]     status_q, status_d;
  logic [15:0]    busy_cnt_q, busy_cnt_d;
  fwp_array_req_s req_q, req_d;
  logic           vcc_ok_q, vcc_ok_d;
  logic           busy;

  always_comb begin
    busy       = busy_cnt_q != 16'h0000;
    front_d    = front_q;
    status_d   = status_q;
    req_d      = req_q;
    req_d.valid = 1'b0;
    busy_cnt_d = busy ? busy_cnt_q - 16'h0001 : busy_cnt_q;               // RQ10
    vcc_ok_d   = sync2_q.vcc_ok;
    status_d[FWP_SR_READY] = !busy;
    if (!sync2_q.hw_reset_n || (sync2_q.vcc_ok && !vcc_ok_q)) begin
      front_d = FWP_FE_READ_ARRAY;                                        // RQ14
    end else if (write_strobe && !busy) begin
      // Apart from hw reset and core supply recovery, only host writes alter the latched command
      unique case (front_q)                                               // RQ13
        FWP_FE_PROG_WAIT, FWP_FE_ERASE_WAIT: begin
          front_d = FWP_FE_READ_STATUS;
          if (front_q == FWP_FE_ERASE_WAIT &&
              sync2_q.data != FWP_CMD_CONFIRM) begin
            status_d[FWP_SR_ERASE_ERR] = 1'b1;
            status_d[FWP_SR_PROG_ERR]  = 1'b1;
          end else if (!sync2_q.vpp_ok) begin                             // RQ17
            status_d[FWP_SR_SUPPLY_ERR] = 1'b1;                           // RQ1
            status_d[front_q == FWP_FE_ERASE_WAIT ? FWP_SR_ERASE_ERR
                                                  : FWP_SR_PROG_ERR] = 1'b1;
          end else if (blk_locked) begin                                  // RQ17
            status_d[FWP_SR_LOCK_ERR] = 1'b1;                             // RQ2
            status_d[front_q == FWP_FE_ERASE_WAIT ? FWP_SR_ERASE_ERR
                                                  : FWP_SR_PROG_ERR] = 1'b1;
          end else begin
            // Second cycle completes the sequence
            req_d.valid     = 1'b1;                                       // RQ12
            req_d.erase     = front_q == FWP_FE_ERASE_WAIT;               // RQ5
            req_d.block     = sync2_q.block;
            req_d.word_addr = sync2_q.word_addr;
            req_d.data      = {8'h00, sync2_q.data};
            busy_cnt_d      = OP_CYCLES[15:0];
            status_d[FWP_SR_READY] = 1'b0;
          end
        end
        default: begin
          unique case (sync2_q.data)
            FWP_CMD_PROG_SETUP: front_d = FWP_FE_PROG_WAIT;
            FWP_CMD_ERASE_SET:  front_d = FWP_FE_ERASE_WAIT;
            FWP_CMD_READ_STAT:  front_d = FWP_FE_READ_STATUS;
            FWP_CMD_CLR_STAT: begin
              front_d  = FWP_FE_READ_STATUS;
              status_d = {status_d[7], 7'h00};
            end
            FWP_CMD_READ_ARRAY: front_d = FWP_FE_READ_ARRAY;
            default:            front_d = front_q;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      front_q    <= FWP_FE_READ_ARRAY;                                    // RQ14
      status_q   <= FWP_SR_RESET;
      busy_cnt_q <= 16'h0000;
      req_q      <= '0;
      vcc_ok_q   <= 1'b1;                                                 // Idle level, no false rise
      wr_prev_q  <= 1'b0;
    end else begin
      front_q    <= front_d;
      status_q   <= status_d;
      busy_cnt_q <= busy_cnt_d;
      req_q      <= req_d;
      vcc_ok_q   <= vcc_ok_d;
      wr_prev_q  <= wr_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Power modes and data pins
  // ----------------------------------------------------------------
  fwp_power_e  power_q, power_d;
  logic [15:0] data_q, data_d;
  logic        oe_q, oe_d;
  logic [15:0] last_addr_q, last_addr_d;
  logic        read_now;

  always_comb begin
    power_d     = power_q;
    data_d      = data_q;
    last_addr_d = last_addr_q;
    read_now    = !sync2_q.chip_sel_n && !sync2_q.out_en_n && sync2_q.hw_reset_n;
    oe_d        = read_now;
    if (!sync2_q.hw_reset_n) begin
      power_d = FWP_PWR_RESET;                                            // RQ6
      oe_d    = 1'b0;
    end else if (sync2_q.chip_sel_n) begin
      // Standby only when idle and in read mode
      if (busy) begin
        power_d = FWP_PWR_ACTIVE;                                         // RQ10
      end else if (front_q == FWP_FE_READ_ARRAY) begin
        power_d = FWP_PWR_STANDBY;                                        // RQ9
      end else begin
        power_d = FWP_PWR_ACTIVE;
      end
      oe_d = 1'b0;                                                        // RQ9
    end else if (front_q == FWP_FE_READ_ARRAY && read_now && oe_q &&
                 last_addr_q == sync2_q.word_addr && !busy) begin
      // Save only once the same word is already driven, never stale data
      power_d = FWP_PWR_AUTO_SAVE;                                        // RQ8
    end else begin
      power_d = FWP_PWR_ACTIVE;                                           // RQ7
      if (read_now) begin
        last_addr_d = sync2_q.word_addr;
        data_d = (front_q == FWP_FE_READ_ARRAY) ? array_rdata             // RQ15
                                                : {8'h00, status_q};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      power_q     <= FWP_PWR_RESET;
      data_q      <= 16'h0000;
      oe_q        <= 1'b0;
      last_addr_q <= 16'h0000;
    end else begin
      power_q     <= power_d;
      data_q      <= data_d;
      oe_q        <= oe_d;
      last_addr_q <= last_addr_d;
    end
  end

  // Outputs straight from flip-flops
  assign data_out   = data_q;
  assign data_oe    = oe_q;
  assign array_req  = req_q;
  assign power_mode = power_q;
  assign status     = status_q;

endmodule

`default_nettype wire

// File: fwp_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fwp_ctrl_assertions
  import fwp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = FWP_OP_CYCLES
) (
  // Clock and pins
  input wire logic           clock,
  input wire logic           reset_n,
  input wire fwp_bus_s       bus_pins,
  // Outputs
  input wire logic [15:0]    data_out,
  input wire logic           data_oe,
  input wire fwp_array_req_s array_req,
  input wire fwp_power_e     power_mode,
  input wire logic [7:0]     status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Protection and power checks
  // ------------------------------------------------------------
  a_hw_reset_hold: assert property (!bus_pins.hw_reset_n [*4] |->
    power_mode == FWP_PWR_RESET && !data_oe) else $error("hw reset not held");
  a_supply_gate: assert property (array_req.valid |->
    $past(bus_pins.vpp_ok, 3)) else $error("request under supply lockout");
  a_wp_lock: assert property (array_req.valid && !$past(bus_pins.write_prot_n, 3)
    |-> array_req.block inside {[31:36]}) else $error("locked block written");
  a_busy_span: assert property (array_req.valid |-> ##1 !status[FWP_SR_READY] [*6]
    ##[1:5] status[FWP_SR_READY]) else $error("busy span wrong");
  a_standby_float: assert property (power_mode == FWP_PWR_STANDBY |-> !data_oe)
    else $error("pins driven in standby");
  a_select_active: assert property ((!bus_pins.chip_sel_n && bus_pins.hw_reset_n) [*5]
    |-> power_mode inside {FWP_PWR_ACTIVE, FWP_PWR_AUTO_SAVE}) else $error("not active");
  a_save_holds: assert property (power_mode == FWP_PWR_AUTO_SAVE &&
    $past(power_mode) == FWP_PWR_AUTO_SAVE |-> $stable(data_out)) else $error("data moved");
  a_write_gate: assert property (bus_pins.write_n [*8] |-> !array_req.valid)
    else $error("request without strobe");
  a_error_no_req: assert property ($rose(status[FWP_SR_LOCK_ERR])
    || $rose(status[FWP_SR_SUPPLY_ERR]) |-> !array_req.valid) else $error("error with request");

  // Main scenarios
  c_request: cover property (array_req.valid);
  c_lock_err: cover property ($rose(status[FWP_SR_LOCK_ERR]));
  c_save: cover property (power_mode == FWP_PWR_AUTO_SAVE);
endmodule
`default_nettype wire

// File: fwp_host.sv
`timescale 1ns/10ps
`default_nettype none
module fwp_host
  import fwp_pkg::*;
(
  // Clock and pins
  input  wire logic    clock,
  output var fwp_bus_s bus_pins
);
  // Idle pins, writes blocked by high strobes
  initial begin
    bus_pins = '{chip_sel_n: 1, write_n: 1, out_en_n: 1, hw_reset_n: 1,
                 write_prot_n: 1, vpp_ok: 1, vcc_ok: 1, default: '0};
  end

  // Command write, data held past strobe rise
  task automatic wr(input logic [7:0] d, input logic [5:0] b);
    @(negedge clock);
    bus_pins.chip_sel_n = 1'b0;
    bus_pins.write_n = 1'b0;
    bus_pins.data = d;
    bus_pins.block = b;
    repeat (2) @(negedge clock);
    bus_pins.write_n = 1'b1;
    bus_pins.chip_sel_n = 1'b1;
    repeat (4) @(negedge clock);
    bus_pins.data = ~d;
  endtask

  // Selected read, left selected for checking
  task automatic rd(input logic [15:0] a);
    @(negedge clock);
    bus_pins.chip_sel_n = 1'b0;
    bus_pins.out_en_n = 1'b0;
    bus_pins.word_addr = a;
    repeat (5) @(negedge clock);
  endtask

  // Deselect
  task automatic rls;
    @(negedge clock);
    bus_pins.chip_sel_n = 1'b1;
    bus_pins.out_en_n = 1'b1;
  endtask

  // Protection pins and hw reset, driven independently of system reset
  task automatic ctl(input logic wp, input logic vpp, input logic rst);
    @(negedge clock);
    bus_pins.write_prot_n = wp;
    bus_pins.vpp_ok = vpp;
    bus_pins.hw_reset_n = rst;
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// File: fwp_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module fwp_ctrl_tb
  import fwp_pkg::*;
;
  logic           clock;
  logic           reset_n;
  fwp_bus_s       bus_pins;
  logic [15:0]    array_rdata;
  logic [15:0]    data_out;
  logic           data_oe;
  fwp_array_req_s array_req;
  fwp_array_req_s got;
  fwp_power_e     power_mode;
  logic [7:0]     status;
  logic           seen;
  int             req_count = 0;
  int             mark = 0;
  int             miscompares = 0;
  int             check_count = 0;

  // Clock and cell data
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  assign array_rdata = ~bus_pins.word_addr;
  assign seen = req_count != mark;

  fwp_ctrl #(.OP_CYCLES(8)) i_fwp_ctrl (.clock(clock), .reset_n(reset_n),
    .bus_pins(bus_pins), .array_rdata(array_rdata), .data_out(data_out),
    .data_oe(data_oe), .array_req(array_req), .power_mode(power_mode), .status(status));
  fwp_host i_fwp_host (.clock(clock), .bus_pins(bus_pins));

  // Request capture
  always @(posedge clock) begin
    if (array_req.valid === 1'b1) begin
      req_count++;
      got = array_req;
    end
  end

  // Second write, then wait for ready
  task automatic fin(input logic [7:0] c, input logic [5:0] b);
    mark = req_count;
    i_fwp_host.wr(c, b);
    for (int i = 0; i < 40 && status[FWP_SR_READY] !== 1'b1; i++) @(negedge clock);
  endtask

  task automatic op(input logic [7:0] s, input logic [7:0] c, input logic [5:0] b);
    i_fwp_host.wr(s, b);
    fin(c, b);
  endtask

  task automatic t_read;
    `CHK(status, FWP_SR_RESET)
    `CHK(power_mode, FWP_PWR_STANDBY)
    i_fwp_host.rd(16'h1234);
    `CHK(data_out, 16'hEDCB)
    `CHK(power_mode, FWP_PWR_AUTO_SAVE)
    `CHK(data_oe, 1'b1)
    i_fwp_host.rls;
    repeat (4) @(negedge clock);
    `CHK(data_oe, 1'b0)
  endtask

  task automatic t_lock;
    logic [5:0] blks [4] = '{6'h1E, 6'h25, 6'h26, 6'h00};
    i_fwp_host.ctl(1'b0, 1'b1, 1'b1);
    op(FWP_CMD_PROG_SETUP, 8'h5A, 6'h1F);
    `CHK(seen, 1'b1)
    `CHK(got, fwp_array_req_s'{1'b1, 1'b0, 6'h1F, 16'h1234, 16'h005A})
    foreach (blks[i]) begin
      op(FWP_CMD_ERASE_SET, FWP_CMD_CONFIRM, blks[i]);
      `CHK(seen, 1'b0)
      `CHK(status[FWP_SR_LOCK_ERR], 1'b1)
      i_fwp_host.wr(FWP_CMD_CLR_STAT, 6'h00);
    end
    i_fwp_host.ctl(1'b1, 1'b1, 1'b1);
    op(FWP_CMD_ERASE_SET, FWP_CMD_CONFIRM, 6'h26);
    `CHK(seen, 1'b1)
    `CHK(got.erase, 1'b1)
  endtask

  task automatic t_supply;
    i_fwp_host.ctl(1'b1, 1'b0, 1'b1);
    op(FWP_CMD_PROG_SETUP, 8'hA5, 6'h20);
    `CHK(seen, 1'b0)
    `CHK(status[FWP_SR_SUPPLY_ERR], 1'b1)
    i_fwp_host.wr(FWP_CMD_CLR_STAT, 6'h00);
    i_fwp_host.wr(FWP_CMD_PROG_SETUP, 6'h20);
    i_fwp_host.ctl(1'b1, 1'b1, 1'b1);
    fin(8'h3C, 6'h20);
    `CHK(seen, 1'b1)
    `CHK(got.data, 16'h003C)
  endtask

  task automatic t_busy;
    i_fwp_host.wr(FWP_CMD_ERASE_SET, 6'h05);
    i_fwp_host.wr(FWP_CMD_CONFIRM, 6'h05);
    `CHK(power_mode, FWP_PWR_ACTIVE)
    `CHK(status[FWP_SR_READY], 1'b0)
    repeat (10) @(negedge clock);
    i_fwp_host.rd(16'h0000);
    `CHK(data_out, 16'h0080)
    i_fwp_host.rls;
    i_fwp_host.wr(FWP_CMD_READ_ARRAY, 6'h00);
    i_fwp_host.rd(16'h0F0F);
    `CHK(data_out, 16'hF0F0)
    i_fwp_host.rls;
  endtask

  task automatic t_hwreset;
    mark = req_count;
    i_fwp_host.wr(FWP_CMD_PROG_SETUP, 6'h1F);
    repeat (10) @(negedge clock);
    `CHK(seen, 1'b0)
    i_fwp_host.ctl(1'b1, 1'b1, 1'b0);
    `CHK(power_mode, FWP_PWR_RESET)
    op(FWP_CMD_PROG_SETUP, 8'h11, 6'h1F);
    `CHK(seen, 1'b0)
    i_fwp_host.ctl(1'b1, 1'b1, 1'b1);
    i_fwp_host.rd(16'h00FF);
    `CHK(data_out, 16'hFF00)
    i_fwp_host.rls;
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (6000) @(posedge clock);
    miscompares++;
    end_of_test;
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_read;
    t_lock;
    t_supply;
    t_busy;
    t_hwreset;
    end_of_test;
  end
endmodule
bind fwp_ctrl fwp_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) i_fwp_ctrl_assertions (
  .clock(clock), .reset_n(reset_n), .bus_pins(bus_pins), .data_out(data_out),
  .data_oe(data_oe), .array_req(array_req), .power_mode(power_mode), .status(status));
`default_nettype wire
